// ### hts_pkg.sv
package hts_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int CNT_W = 28;
  localparam int DET_US = 100;
  localparam int ONE_MS = 1000;
  localparam int FAIL_MS = 2000;
  localparam int START_MS = 20;
  localparam int RST_MS = 10;
  localparam int BEEP_HALF_MS = 125;
  localparam logic [CNT_W-1:0] DET_CYC = CNT_W'(DET_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] ONE_CYC = CNT_W'(ONE_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] STRETCH_CYC =
    CNT_W'((FAIL_MS - ONE_MS) * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] START_CYC =
    CNT_W'(START_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] RST_CYC = CNT_W'(RST_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] BEEP_CYC =
    CNT_W'(BEEP_HALF_MS * 1000 * CLK_MHZ);

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_EN = 8'h0c;
  localparam logic [7:0] OFS_INT_CLR = 8'h10;
  localparam logic [7:0] OFS_TRIP0 = 8'h14;
  localparam int NUM_TRIP = 5;
  localparam int TRIP_W = 12;

  // CTRL fields
  localparam int CTRL_PRECHK = 0;
  localparam int CTRL_TONE = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // STATUS fields
  localparam int ST_START = 0;
  localparam int ST_TEST = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_ALARM = 3;
  localparam int ST_TRIP = 4;
  localparam int ST_URST = 5;
  localparam int ST_SEL = 8;

  // Interrupt bits
  localparam int IRQ_W = 5;
  localparam int IRQ_PRESS = 0;
  localparam int IRQ_REL = 1;
  localparam int IRQ_FAILEND = 2;
  localparam int IRQ_TRIP = 3;
  localparam int IRQ_URST = 4;

  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] SEL_REAR = 3'h5;

endpackage

// ### hts_tmr_if.sv
`timescale 1ns/1ps
interface hts_tmr_if;
  logic trig;
  logic busy;
  logic done;
  modport tmr (input trig, output busy, output done);
  modport user (output trig, input busy, input done);
endinterface

// ### hts_timer.sv
`timescale 1ns/1ps
module hts_timer #(
  parameter logic [hts_pkg::CNT_W-1:0] LEN = hts_pkg::CNT_W'(1)
) (
  input wire logic pclk,
  input wire logic presetn,
  hts_tmr_if.tmr t
);

  typedef struct packed {
    logic [hts_pkg::CNT_W-1:0] cnt;
    logic busy;
    logic done;
  } hts_tmr_st_t;

  hts_tmr_st_t st_ff;
  hts_tmr_st_t nxt_st;

  // Retrigger while busy is ignored, so each pulse has exactly LEN cycles
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (st_ff.busy) begin
      if (st_ff.cnt == '0) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt - 1'b1;
      end
    end else if (t.trig) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt = LEN - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign t.busy = st_ff.busy;
  assign t.done = st_ff.done;

endmodule

// ### hts_supervisor.sv
`timescale 1ns/1ps
module hts_supervisor #(
  parameter logic [hts_pkg::CNT_W-1:0] DET_LEN = hts_pkg::DET_CYC,
  parameter logic [hts_pkg::CNT_W-1:0] ONE_LEN = hts_pkg::ONE_CYC,
  parameter logic [hts_pkg::CNT_W-1:0] STRETCH_LEN = hts_pkg::STRETCH_CYC,
  parameter logic [hts_pkg::CNT_W-1:0] START_LEN = hts_pkg::START_CYC,
  parameter logic [hts_pkg::CNT_W-1:0] RST_LEN = hts_pkg::RST_CYC,
  parameter logic [hts_pkg::CNT_W-1:0] BEEP_LEN = hts_pkg::BEEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_n,
  input wire logic test_n,
  input wire logic prechk_start,
  input wire logic [hts_pkg::SEL_W-1:0] trip_sel,
  input wire logic [hts_pkg::TRIP_W-1:0] rear_trip,
  input wire logic [hts_pkg::TRIP_W-1:0] cur_meas,
  output logic start_pulse,
  output logic detect_n,
  output logic fail_lamp,
  output logic alarm,
  output logic unit_reset,
  output logic irq
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic start_s1;
    logic start_s2;
    logic test_s1;
    logic test_s2;
    logic pchk_s1;
    logic pchk_s2;
    logic [hts_pkg::SEL_W-1:0] sel_s1;
    logic [hts_pkg::SEL_W-1:0] sel_s2;
    logic start_q;
    logic pchk_q;
    logic rel_q;
    logic det_q;
    logic trip_q;
    logic urst_q;
    logic restart_seen;
    logic beep_on;
    logic fail_o;
    logic alarm_o;
    logic [1:0] ctrl;
    logic [hts_pkg::NUM_TRIP-1:0][hts_pkg::TRIP_W-1:0] trip_set;
    logic [hts_pkg::IRQ_W-1:0] int_stat;
    logic [hts_pkg::IRQ_W-1:0] int_en;
    logic [31:0] rdata;
    logic rderr;
  } hts_st_t;

  hts_st_t st_ff;
  hts_st_t nxt_st;

  // ------------------------------------------------------------------
  // Timers
  // ------------------------------------------------------------------
  hts_tmr_if det_t ();
  hts_tmr_if one_t ();
  hts_tmr_if str_t ();
  hts_tmr_if sp_t ();
  hts_tmr_if rst_t ();
  hts_tmr_if beep_t ();

  hts_timer #(.LEN(DET_LEN)) u_det (
    .pclk(pclk),
    .presetn(presetn),
    .t(det_t.tmr)
  );
  hts_timer #(.LEN(ONE_LEN)) u_one (
    .pclk(pclk),
    .presetn(presetn),
    .t(one_t.tmr)
  );
  hts_timer #(.LEN(STRETCH_LEN)) u_str (
    .pclk(pclk),
    .presetn(presetn),
    .t(str_t.tmr)
  );
  hts_timer #(.LEN(START_LEN)) u_sp (
    .pclk(pclk),
    .presetn(presetn),
    .t(sp_t.tmr)
  );
  hts_timer #(.LEN(RST_LEN)) u_rst (
    .pclk(pclk),
    .presetn(presetn),
    .t(rst_t.tmr)
  );
  hts_timer #(.LEN(BEEP_LEN)) u_beep (
    .pclk(pclk),
    .presetn(presetn),
    .t(beep_t.tmr)
  );

  // ------------------------------------------------------------------
  // Conditioned inputs
  // ------------------------------------------------------------------
  logic start_i;
  logic test_i;
  logic press;
  logic pchk_edge;
  logic rel_cond;
  logic rel_edge;
  logic fail_busy;
  logic cycle_busy;
  logic [hts_pkg::TRIP_W-1:0] thr;
  logic trip_now;
  logic [hts_pkg::IRQ_W-1:0] ev;

  // inverted so held switch and testing read high
  assign start_i = ~st_ff.start_s2;
  assign test_i = ~st_ff.test_s2;

  // press is the falling edge of the raw start
  assign press = start_i & ~st_ff.start_q;
  assign pchk_edge = st_ff.pchk_s2 & ~st_ff.pchk_q;

  // start released, or not held when the test comes up
  // armed only while the test flag is high
  assign rel_cond = test_i & ~start_i;
  assign rel_edge = rel_cond & ~st_ff.rel_q;

  // The one-second done cycle counts as busy, so that the handover to the
  // stretch timer opens no gap for a new release or a lost restart
  assign fail_busy = det_t.busy | one_t.busy | one_t.done | str_t.busy;
  assign cycle_busy = fail_busy | rst_t.busy;

  // six-position selector, five settings plus the rear dial
  always_comb begin
    if (st_ff.sel_s2 < hts_pkg::SEL_REAR) begin
      thr = st_ff.trip_set[st_ff.sel_s2];
    end else begin
      thr = rear_trip;
    end
  end

  // current at or above the selected point trips
  assign trip_now = test_i & (cur_meas >= thr);

  // ------------------------------------------------------------------
  // Timer triggers
  // ------------------------------------------------------------------
  // one detect pulse per release, not retriggered mid-fail
  assign det_t.trig = rel_edge & ~cycle_busy;

  // detect pulse starts the one-second timer
  assign one_t.trig = det_t.busy & ~st_ff.det_q;

  // stretch the one-second pulse to the full fail time
  assign str_t.trig = one_t.done;

  // unit reset only if nobody tried to restart during fail
  assign rst_t.trig = str_t.done & ~st_ff.restart_seen;

  // pre-check unit owns the start pulse when fitted
  // one start pulse per press, held off during fail and reset
  always_comb begin
    if (st_ff.ctrl[hts_pkg::CTRL_PRECHK]) begin
      sp_t.trig = pchk_edge & ~cycle_busy;
    end else begin
      sp_t.trig = press & ~cycle_busy;
    end
  end

  // free-running beep clock only during a test
  assign beep_t.trig = st_ff.ctrl[hts_pkg::CTRL_TONE] & test_i;

  // ------------------------------------------------------------------
  // Interrupt events
  // ------------------------------------------------------------------
  always_comb begin
    ev = '0;
    ev[hts_pkg::IRQ_PRESS] = press;
    ev[hts_pkg::IRQ_REL] = det_t.trig;
    ev[hts_pkg::IRQ_FAILEND] = str_t.done;
    ev[hts_pkg::IRQ_TRIP] = trip_now & ~st_ff.trip_q;
    ev[hts_pkg::IRQ_URST] = rst_t.busy & ~st_ff.urst_q;
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  logic wr_acc;
  logic rd_setup;
  logic [hts_pkg::IRQ_W-1:0] clr_mask;

  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_comb begin
    nxt_st = st_ff;
    clr_mask = '0;

    nxt_st.start_s1 = start_n;
    nxt_st.start_s2 = st_ff.start_s1;
    nxt_st.test_s1 = test_n;
    nxt_st.test_s2 = st_ff.test_s1;
    nxt_st.pchk_s1 = prechk_start;
    nxt_st.pchk_s2 = st_ff.pchk_s1;
    nxt_st.sel_s1 = trip_sel;
    nxt_st.sel_s2 = st_ff.sel_s1;

    nxt_st.start_q = start_i;
    nxt_st.pchk_q = st_ff.pchk_s2;
    nxt_st.rel_q = rel_cond;
    nxt_st.det_q = det_t.busy;
    nxt_st.trip_q = trip_now;
    nxt_st.urst_q = rst_t.busy;

    // a press during the fail counts as a restart attempt
    if (press & fail_busy) begin
      nxt_st.restart_seen = 1'b1;
    end else if (~fail_busy) begin
      nxt_st.restart_seen = 1'b0;
    end

    // toggle every half period, silent outside a test
    if (~test_i | ~st_ff.ctrl[hts_pkg::CTRL_TONE]) begin
      nxt_st.beep_on = 1'b0;
    end else if (beep_t.done) begin
      nxt_st.beep_on = ~st_ff.beep_on;
    end

    // fail lamp and alarm together while the one-second or stretch timer is busy
    nxt_st.fail_o = one_t.busy | str_t.busy | trip_now;
    nxt_st.alarm_o = one_t.busy | str_t.busy | trip_now | st_ff.beep_on;

    // Register writes take effect in the access phase
    if (wr_acc) begin
      unique case (paddr)
        hts_pkg::OFS_CTRL: nxt_st.ctrl = pwdata[1:0];
        hts_pkg::OFS_INT_EN: nxt_st.int_en = pwdata[hts_pkg::IRQ_W-1:0];
        hts_pkg::OFS_INT_CLR: clr_mask = pwdata[hts_pkg::IRQ_W-1:0];
        default: begin
          for (int i = 0; i < hts_pkg::NUM_TRIP; i++) begin
            if (paddr == hts_pkg::OFS_TRIP0 + 8'(4 * i)) begin
              nxt_st.trip_set[i] = pwdata[hts_pkg::TRIP_W-1:0];
            end
          end
        end
      endcase
    end

    // Set wins over a clear in the same cycle
    nxt_st.int_stat = (st_ff.int_stat & ~clr_mask) | ev;

    // Read data is captured in setup so it is stable in access
    if (rd_setup) begin
      nxt_st.rdata = '0;
      nxt_st.rderr = 1'b0;
      unique case (paddr)
        hts_pkg::OFS_CTRL: nxt_st.rdata[1:0] = st_ff.ctrl;
        hts_pkg::OFS_STATUS: begin
          nxt_st.rdata[hts_pkg::ST_START] = start_i;
          nxt_st.rdata[hts_pkg::ST_TEST] = test_i;
          nxt_st.rdata[hts_pkg::ST_FAIL] = st_ff.fail_o;
          nxt_st.rdata[hts_pkg::ST_ALARM] = st_ff.alarm_o;
          nxt_st.rdata[hts_pkg::ST_TRIP] = trip_now;
          nxt_st.rdata[hts_pkg::ST_URST] = rst_t.busy;
          nxt_st.rdata[hts_pkg::ST_SEL +: hts_pkg::SEL_W] = st_ff.sel_s2;
        end
        hts_pkg::OFS_INT_STAT:
          nxt_st.rdata[hts_pkg::IRQ_W-1:0] = st_ff.int_stat;
        hts_pkg::OFS_INT_EN:
          nxt_st.rdata[hts_pkg::IRQ_W-1:0] = st_ff.int_en;
        hts_pkg::OFS_INT_CLR: nxt_st.rdata = '0;
        default: begin
          nxt_st.rderr = 1'b1;
          for (int i = 0; i < hts_pkg::NUM_TRIP; i++) begin
            if (paddr == hts_pkg::OFS_TRIP0 + 8'(4 * i)) begin
              nxt_st.rdata[hts_pkg::TRIP_W-1:0] = st_ff.trip_set[i];
              nxt_st.rderr = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Synchronisers reset to the idle (released, not testing) level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.start_s1 <= 1'b1;
      st_ff.start_s2 <= 1'b1;
      st_ff.test_s1 <= 1'b1;
      st_ff.test_s2 <= 1'b1;
      st_ff.ctrl <= hts_pkg::CTRL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------------
  // Write error decode
  // ------------------------------------------------------------------
  logic wr_err;

  always_comb begin
    wr_err = 1'b1;
    if (paddr == hts_pkg::OFS_CTRL || paddr == hts_pkg::OFS_INT_EN ||
        paddr == hts_pkg::OFS_INT_CLR) begin
      wr_err = 1'b0;
    end
    for (int k = 0; k < hts_pkg::NUM_TRIP; k++) begin
      if (paddr == hts_pkg::OFS_TRIP0 + 8'(4 * k)) begin
        wr_err = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & (pwrite ? wr_err : st_ff.rderr);
  assign prdata = st_ff.rdata;

  assign start_pulse = sp_t.busy;
  // idle high whenever no release is being flagged
  // low for the detect pulse length
  assign detect_n = ~det_t.busy;
  assign fail_lamp = st_ff.fail_o;
  assign alarm = st_ff.alarm_o;
  assign unit_reset = rst_t.busy;
  assign irq = |(st_ff.int_stat & st_ff.int_en);

endmodule

// ### hts_chk.sv
`timescale 1ns/1ps
module hts_chk #(
  parameter logic [hts_pkg::CNT_W-1:0] DET_LEN = hts_pkg::DET_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic start_n,
  input wire logic test_n,
  input wire logic prechk_start,
  input wire logic [hts_pkg::SEL_W-1:0] trip_sel,
  input wire logic [hts_pkg::TRIP_W-1:0] rear_trip,
  input wire logic [hts_pkg::TRIP_W-1:0] cur_meas,
  input wire logic start_pulse,
  input wire logic detect_n,
  input wire logic fail_lamp,
  input wire logic alarm,
  input wire logic unit_reset,
  input wire logic irq
);
  // ------------------------------------------------------------------
  // Helper counters, saturating so long idle spans do not wrap
  // ------------------------------------------------------------------
  logic [7:0] lo_ff, tst_ff, prs_ff, fl_ff;
  function automatic logic [7:0] sat(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_ff <= 8'h00;
      tst_ff <= 8'hff;
      prs_ff <= 8'hff;
      fl_ff <= 8'hff;
    end else begin
      lo_ff <= detect_n ? 8'h00 : sat(lo_ff);
      tst_ff <= !test_n ? 8'h00 : sat(tst_ff);
      prs_ff <= (!start_n || prechk_start) ? 8'h00 : sat(prs_ff);
      fl_ff <= fail_lamp ? 8'h00 : sat(fl_ff);
    end
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_four(logic s);
    s [*4] ##1 !s;
  endsequence
  sequence s_fail_on;
    ##[1:6] (fail_lamp [*8]);
  endsequence
  pready_hi_a: assert property (pready)
    else $error("pready low");
  bad_addr_a: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
    else $error("no error on unmapped address");
  det_width_a: assert property ($rose(detect_n) |-> lo_ff == DET_LEN[7:0])
    else $error("detect pulse width wrong");
  det_armed_a: assert property ($fell(detect_n) |-> tst_ff < 8'h08)
    else $error("detect while not testing");
  det_fail_a: assert property ($fell(detect_n) |-> s_fail_on)
    else $error("no fail after detect");
  fail_alarm_a: assert property (fail_lamp |-> alarm)
    else $error("fail without alarm");
  start_len_a: assert property ($rose(start_pulse) |-> s_four(start_pulse))
    else $error("start pulse width wrong");
  start_cause_a: assert property ($rose(start_pulse) |-> prs_ff < 8'h06)
    else $error("start pulse without press");
  urst_len_a: assert property ($rose(unit_reset) |-> s_four(unit_reset))
    else $error("unit reset width wrong");
  urst_cause_a: assert property ($rose(unit_reset) |-> fl_ff < 8'h06)
    else $error("unit reset without fail end");
endmodule
bind hts_supervisor hts_chk #(.DET_LEN(DET_LEN)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .start_n(start_n), .test_n(test_n),
  .prechk_start(prechk_start), .trip_sel(trip_sel), .rear_trip(rear_trip),
  .cur_meas(cur_meas), .start_pulse(start_pulse), .detect_n(detect_n),
  .fail_lamp(fail_lamp), .alarm(alarm), .unit_reset(unit_reset), .irq(irq)
);

// ### hts_op.sv
`timescale 1ns/1ps
module hts_op (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold,
  output logic start_n
);
  // ------------------------------------------------------------------
  // Operator switch: low while held, no bounce modelled
  // ------------------------------------------------------------------
  // start held low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_n <= 1'b1;
    end else begin
      start_n <= ~hold;
    end
  end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ------------------------------------------------------------------
  // Stimulus and checks
  // ------------------------------------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, hold = 1'b0, test_n = 1'b1, prechk_start = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0] trip_sel = 3'h0;
  logic [11:0] rear_trip = 12'h200, cur_meas = 12'h000;
  logic pready, pslverr, start_n, start_pulse, detect_n;
  logic fail_lamp, alarm, unit_reset, irq;
  int n_mismatch = 0, samples_checked = 0;
  // Short timer lengths so that a whole fail cycle fits in a few hundred
  localparam logic [hts_pkg::CNT_W-1:0] DET_L = 28'h8;
  localparam logic [hts_pkg::CNT_W-1:0] ONE_L = 28'h10;
  localparam logic [hts_pkg::CNT_W-1:0] STR_L = 28'h10;
  localparam logic [hts_pkg::CNT_W-1:0] SP_L = 28'h4;
  localparam logic [hts_pkg::CNT_W-1:0] RST_L = 28'h4;
  localparam logic [hts_pkg::CNT_W-1:0] BEEP_L = 28'h6;
  initial forever #5 pclk = ~pclk;
  hts_op op_u (.pclk(pclk), .presetn(presetn), .hold(hold),
    .start_n(start_n));
  hts_supervisor #(.DET_LEN(DET_L), .ONE_LEN(ONE_L), .STRETCH_LEN(STR_L),
    .START_LEN(SP_L), .RST_LEN(RST_L), .BEEP_LEN(BEEP_L)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .start_n(start_n), .test_n(test_n),
    .prechk_start(prechk_start), .trip_sel(trip_sel), .rear_trip(rear_trip),
    .cur_meas(cur_meas), .start_pulse(start_pulse), .detect_n(detect_n),
    .fail_lamp(fail_lamp), .alarm(alarm), .unit_reset(unit_reset), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, {31'h0, x});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  // Counts high cycles of start_pulse, ~detect_n, fail_lamp with alarm, unit_reset
  task automatic watch(input int n, output int c[4]);
    c = '{0, 0, 0, 0};
    repeat (n) begin
      @(posedge pclk);
      c[0] += int'(start_pulse === 1'b1);
      c[1] += int'(detect_n === 1'b0);
      c[2] += int'(fail_lamp === 1'b1 && alarm === 1'b1);
      c[3] += int'(unit_reset === 1'b1);
    end
  endtask
  task automatic t_regs();
    rd(8'h00, 32'h0, 1'b0);
    rd(8'h0c, 32'h0, 1'b0);
    rd(8'h14, 32'h0, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    wr(8'h04, 32'h1, 1'b1);
    rd(8'h10, 32'h0, 1'b0);
  endtask
  task automatic t_press();
    int c[4];
    wr(8'h0c, 32'h1, 1'b0);
    hold <= 1'b1;
    watch(20, c);
    chk(32'(c[0]), 32'(SP_L));
    chk({31'h0, irq}, 32'h1);
    rd(8'h08, 32'h1, 1'b0);
    wr(8'h0c, 32'h0, 1'b0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h0c, 32'h1, 1'b0);
    wr(8'h10, 32'h1, 1'b0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    hold <= 1'b0;
    watch(20, c);
    chk(32'(c[1]), 32'h0);
  endtask
  task automatic t_prechk();
    int c[4];
    wr(8'h00, 32'h1, 1'b0);
    hold <= 1'b1;
    watch(20, c);
    chk(32'(c[0]), 32'h0);
    prechk_start <= 1'b1;
    watch(20, c);
    chk(32'(c[0]), 32'(SP_L));
    prechk_start <= 1'b0;
    hold <= 1'b0;
    wr(8'h00, 32'h0, 1'b0);
  endtask
  // With again set, start is pressed anew during the fail time
  task automatic t_release(input logic again);
    int c[4];
    int d[4];
    trip_sel <= 3'h5;
    hold <= 1'b1;
    repeat (20) @(posedge pclk);
    test_n <= 1'b0;
    watch(8, c);
    chk(32'(c[1]), 32'h0);
    wr(8'h10, 32'h1f, 1'b0);
    hold <= 1'b0;
    watch(10, c);
    hold <= again;
    test_n <= 1'b1;
    watch(90, d);
    chk(32'(c[1] + d[1]), 32'(DET_L));
    chk(32'(c[2] + d[2]), 32'(ONE_L + STR_L));
    chk(32'(d[3]), again ? 32'h0 : 32'(RST_L));
    chk(32'(c[0] + d[0]), 32'h0);
    rd(8'h08, again ? 32'h07 : 32'h16, 1'b0);
    wr(8'h10, 32'h1f, 1'b0);
    hold <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task automatic t_trip();
    logic [11:0] thr;
    for (int i = 0; i < 5; i++) begin
      wr(8'h14 + 8'(4 * i), 32'h100 + 32'(16 * i), 1'b0);
      rd(8'h14 + 8'(4 * i), 32'h100 + 32'(16 * i), 1'b0);
    end
    rear_trip <= 12'h180;
    hold <= 1'b1;
    repeat (8) @(posedge pclk);
    test_n <= 1'b0;
    for (int s = 0; s < 6; s++) begin
      trip_sel <= 3'(s);
      thr = (s < 5) ? 12'h100 + 12'(16 * s) : 12'h180;
      cur_meas <= thr - 12'h1;
      repeat (6) @(posedge pclk);
      chk({31'h0, fail_lamp}, 32'h0);
      cur_meas <= thr;
      repeat (6) @(posedge pclk);
      chk({30'h0, fail_lamp, alarm}, 32'h3);
    end
    cur_meas <= 12'h000;
    repeat (6) @(posedge pclk);
    rd(8'h04, 32'h503, 1'b0);
    test_n <= 1'b1;
    repeat (8) @(posedge pclk);
    hold <= 1'b0;
  endtask
  task automatic t_tone();
    int r;
    logic p;
    r = 0;
    wr(8'h00, 32'h2, 1'b0);
    hold <= 1'b1;
    repeat (8) @(posedge pclk);
    test_n <= 1'b0;
    repeat (8) @(posedge pclk);
    p = alarm;
    repeat (48) begin
      @(posedge pclk);
      r += int'(alarm === 1'b1 && p === 1'b0);
      p = alarm;
    end
    chk(32'(r), 32'h4);
    test_n <= 1'b1;
    repeat (8) @(posedge pclk);
    hold <= 1'b0;
    wr(8'h00, 32'h0, 1'b0);
  endtask
  task automatic results();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_press();
    t_prechk();
    t_release(1'b0);
    t_trip();
    t_tone();
    t_release(1'b1);
    results();
  end
  // A few hundred cycles are expected; this span leaves wide margin
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    results();
  end
endmodule
